// [dv/tsbie_props.sv]
// Assertion checker for the tx slip interrupt enable block
`timescale 1ns/100ps

module tsbie_props
    import tsbie_pkg::*;
(
    input  wire logic              sys_clk_i,      // Clock
    input  wire logic              sys_rst_i,      // Reset
    input  wire logic [ADDR_W-1:0] addr_i,         // Address
    input  wire logic [DATA_W-1:0] wr_data_i,      // Write data
    input  wire logic              wr_i,           // Write strobe
    input  wire logic              rd_i,           // Read strobe
    input  wire logic [DATA_W-1:0] rd_data_o,      // Read data
    input  wire logic              tx_buf_full_i,  // Buffer full
    input  wire logic              tx_buf_empty_i, // Buffer empty
    input  wire logic              tx_buf_wr_i,    // Buffer write
    input  wire logic              tx_buf_rd_i,    // Buffer read
    input  wire logic              drop_frame_o,   // Delete pulse
    input  wire logic              rpt_frame_o,    // Repeat pulse
    input  wire logic              irq_o           // Interrupt
);
    logic [2:0] en_q;
    logic       rd_quiet;

    // Status read while neither buffer level can set a flag
    assign rd_quiet = rd_i && addr_i == OFS_STATUS && !tx_buf_full_i && !tx_buf_empty_i;

    // Shadow of the enable field, used to predict the interrupt
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            en_q <= 3'h0;
        end else if (wr_i && addr_i == OFS_ENABLE) begin
            en_q <= wr_data_i[7:5];
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_drop_on_full: assert property (tx_buf_full_i && tx_buf_wr_i |=> drop_frame_o)
        else $error("drop pulse missing");
    a_drop_no_cause: assert property (!(tx_buf_full_i && tx_buf_wr_i) |=> !drop_frame_o)
        else $error("drop pulse without cause");
    a_rpt_on_empty: assert property (tx_buf_empty_i && tx_buf_rd_i |=> rpt_frame_o)
        else $error("repeat pulse missing");
    a_slip_irq: assert property (tx_buf_full_i && tx_buf_wr_i ##1 en_q[0] |-> ##1 irq_o)
        else $error("slip interrupt missing");
    a_full_irq: assert property ($rose(tx_buf_full_i) ##1 en_q[2] |-> ##1 irq_o)
        else $error("full interrupt missing");
    a_empty_irq: assert property ($rose(tx_buf_empty_i) ##1 en_q[1] |-> ##1 irq_o)
        else $error("empty interrupt missing");
    a_rpt_slip: assert property (tx_buf_empty_i && tx_buf_rd_i ##1 en_q[0] |-> ##1 irq_o)
        else $error("repeat slip interrupt missing");
    a_rd_clear: assert property (rd_quiet |-> ##2 !irq_o)
        else $error("interrupt kept after status read");
    a_irq_masked: assert property (en_q == 3'h0 |=> !irq_o)
        else $error("interrupt while all masked");
    a_rd_enable: assert property (rd_i && addr_i == OFS_ENABLE |=> rd_data_o == {$past(en_q), 5'h00})
        else $error("enable readback wrong");
    a_rd_idle: assert property (!rd_i |=> rd_data_o == 8'h00)
        else $error("read data outside read cycle");

    c_drop: cover property (drop_frame_o);
    c_rpt: cover property (rpt_frame_o);
    c_irq: cover property (irq_o);
    c_rd_clear: cover property (rd_quiet);
endmodule

bind tsbie_top tsbie_props u_tsbie_props (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .tx_buf_full_i(tx_buf_full_i),
    .tx_buf_empty_i(tx_buf_empty_i), .tx_buf_wr_i(tx_buf_wr_i), .tx_buf_rd_i(tx_buf_rd_i),
    .drop_frame_o(drop_frame_o), .rpt_frame_o(rpt_frame_o), .irq_o(irq_o)
);

// [dv/tsbie_top_tb.sv]
// Self-checking testbench for the tx slip interrupt enable block
`timescale 1ns/100ps

module tsbie_top_tb
    import tsbie_pkg::*;
();
    logic       clk   = 1'b0;
    logic       rst   = 1'b1;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic       full  = 1'b0;
    logic       empty = 1'b0;
    logic       bwr   = 1'b0;
    logic       brd   = 1'b0;
    logic [7:0] addr  = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       drop;
    logic       rpt;
    logic       irq;
    int         fails = 0;
    int         n_tests = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    tsbie_top u_tsbie_top (
        .sys_clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr),
        .rd_i(rd), .rd_data_o(rdata), .tx_buf_full_i(full), .tx_buf_empty_i(empty),
        .tx_buf_wr_i(bwr), .tx_buf_rd_i(brd), .drop_frame_o(drop), .rpt_frame_o(rpt),
        .irq_o(irq)
    );

    // ********************************************************
    // Compare and bus tasks
    // ********************************************************
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: bit %b, want %b", $time, got, exp);
        end
    endtask

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask

    // Set buffer levels and pulse buffer accesses, then settle mid-cycle
    task ev(input logic f, input logic e, input logic w, input logic r);
        @(posedge clk);
        full <= f;
        empty <= e;
        bwr <= w;
        brd <= r;
        @(posedge clk);
        bwr <= 1'b0;
        brd <= 1'b0;
        @(negedge clk);
    endtask

    task end_sim;
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task t_regs;
        rd_reg(OFS_ENABLE, 8'h00);
        wr_reg(OFS_ENABLE, 8'hff);
        rd_reg(OFS_ENABLE, 8'he0);
        rd_reg(8'h3f, 8'h00);
    endtask

    task t_overflow;
        wr_reg(OFS_ENABLE, 8'h80);
        ev(1'b1, 1'b0, 1'b1, 1'b0);
        chk_bit(drop, 1'b1);
        @(negedge clk);
        chk_bit(irq, 1'b1);
        ev(1'b0, 1'b0, 1'b0, 1'b0);
        rd_reg(OFS_STATUS, 8'ha0);
        rd_reg(OFS_STATUS, 8'h00);
        chk_bit(irq, 1'b0);
    endtask

    task t_underflow;
        wr_reg(OFS_ENABLE, 8'h40);
        ev(1'b0, 1'b1, 1'b0, 1'b1);
        chk_bit(rpt, 1'b1);
        @(negedge clk);
        chk_bit(irq, 1'b1);
        ev(1'b0, 1'b0, 1'b0, 1'b0);
        rd_reg(OFS_STATUS, 8'h60);
    endtask

    task t_mask;
        wr_reg(OFS_ENABLE, 8'h00);
        ev(1'b1, 1'b0, 1'b1, 1'b0);
        ev(1'b0, 1'b0, 1'b0, 1'b0);
        chk_bit(irq, 1'b0);
        wr_reg(OFS_ENABLE, 8'h40);
        repeat (2) @(negedge clk);
        chk_bit(irq, 1'b0);
        wr_reg(OFS_ENABLE, 8'h20);
        repeat (2) @(negedge clk);
        chk_bit(irq, 1'b1);
        wr_reg(OFS_STATUS, 8'he0);
        repeat (2) @(negedge clk);
        chk_bit(irq, 1'b0);
    endtask

    // Buffer filling with no write sets the overflow flag alone
    task t_full_rise;
        wr_reg(OFS_ENABLE, 8'h80);
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        chk_bit(drop, 1'b0);
        @(negedge clk);
        chk_bit(irq, 1'b1);
        ev(1'b0, 1'b0, 1'b0, 1'b0);
        rd_reg(OFS_STATUS, 8'h80);
    endtask

    // Event in the cycle of a status read survives the clear
    task t_set_wins;
        @(posedge clk);
        addr <= OFS_STATUS;
        rd <= 1'b1;
        full <= 1'b1;
        bwr <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        bwr <= 1'b0;
        @(negedge clk);
        chk(rdata, 8'h00);
        ev(1'b0, 1'b0, 1'b0, 1'b0);
        rd_reg(OFS_STATUS, 8'ha0);
    endtask

    // Mid-run reset returns enables, flags and the overflow counter to zero
    task t_reset;
        wr_reg(OFS_ENABLE, 8'he0);
        ev(1'b1, 1'b0, 1'b1, 1'b0);
        ev(1'b0, 1'b0, 1'b0, 1'b0);
        rd_reg(OFS_OVF_COUNT, 8'h04);
        rd_reg(OFS_UNF_COUNT, 8'h01);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(OFS_ENABLE, 8'h00);
        rd_reg(OFS_STATUS, 8'h00);
        rd_reg(OFS_OVF_COUNT, 8'h00);
        chk_bit(irq, 1'b0);
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_overflow();
        t_underflow();
        t_mask();
        t_full_rise();
        t_set_wins();
        t_reset();
        end_sim();
    end

    // Watchdog against a hang
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        end_sim();
    end
endmodule

// [hw/tsbie_pkg.sv]
// Package of offsets, field positions and reset values for the tx slip interrupt enables
package tsbie_pkg;

    // ********************************************************
    // Register bus geometry
    // ********************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h08; // Slip buffer interrupt status
    localparam logic [ADDR_W-1:0] OFS_ENABLE    = 8'h09; // Slip buffer interrupt enable
    localparam logic [ADDR_W-1:0] OFS_OVF_COUNT = 8'h10; // Frames deleted, saturating
    localparam logic [ADDR_W-1:0] OFS_UNF_COUNT = 8'h11; // Frames repeated, saturating

    // ********************************************************
    // Field positions, shared by status and enable
    // ********************************************************
    localparam int unsigned BIT_TX_OVERFLOW = 7;
    localparam int unsigned BIT_TX_UNDERFLOW = 6;
    localparam int unsigned BIT_TX_SLIP      = 5;
    localparam int unsigned TX_FIELD_LSB     = 5;
    localparam int unsigned TX_FIELD_W       = 3;

    // Index of each event inside the three-bit transmit field
    localparam int unsigned IDX_SLIP      = BIT_TX_SLIP - TX_FIELD_LSB;
    localparam int unsigned IDX_UNDERFLOW = BIT_TX_UNDERFLOW - TX_FIELD_LSB;
    localparam int unsigned IDX_OVERFLOW  = BIT_TX_OVERFLOW - TX_FIELD_LSB;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [TX_FIELD_W-1:0] RST_ENABLE = 3'h0;
    localparam logic [TX_FIELD_W-1:0] RST_STATUS = 3'h0;
    localparam logic [DATA_W-1:0]     RST_RDATA  = 8'h00;

endpackage

// [hw/tsbie_sticky.sv]
// Sticky event flags with read and write-one clear, set winning over clear
`timescale 1ns/100ps

module tsbie_sticky
    import tsbie_pkg::*;
#(
    parameter int unsigned WIDTH = 3
) (
    input  wire logic             sys_clk_i,  // System clock
    input  wire logic             sys_rst_i,  // Synchronous reset, active high
    input  wire logic [WIDTH-1:0] set_i,      // Event pulses, one per flag
    input  wire logic [WIDTH-1:0] clr_i,      // Clear request, one per flag
    output logic      [WIDTH-1:0] flag_o      // Sticky flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flag;
    } tsbie_sticky_t;

    tsbie_sticky_t st;
    tsbie_sticky_t next_st;

    // Clear first, then set, so an event in the clearing cycle is kept
    always_comb begin
        next_st      = st;
        next_st.flag = (st.flag & ~clr_i) | set_i;
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            st.flag <= WIDTH'(RST_STATUS);
        end else begin
            st <= next_st;
        end
    end

    assign flag_o = st.flag;

endmodule

// [hw/tsbie_top.sv]
// Transmit slip buffer interrupt enables, status flags and slip actions
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/100ps

module tsbie_top
    import tsbie_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    input  wire logic              sys_clk_i,      // System clock, 20 MHz
    input  wire logic              sys_rst_i,      // Synchronous reset, active high
    input  wire logic [ADDR_W-1:0] addr_i,         // Register address
    input  wire logic [DATA_W-1:0] wr_data_i,      // Register write data
    input  wire logic              wr_i,           // Write strobe
    input  wire logic              rd_i,           // Read strobe
    output logic      [DATA_W-1:0] rd_data_o,      // Read data, cycle after strobe
    input  wire logic              tx_buf_full_i,  // Tx slip buffer is full
    input  wire logic              tx_buf_empty_i, // Tx slip buffer is empty
    input  wire logic              tx_buf_wr_i,    // Write into tx slip buffer
    input  wire logic              tx_buf_rd_i,    // Read from tx slip buffer
    output logic                   drop_frame_o,   // Pulse: delete one frame
    output logic                   rpt_frame_o,    // Pulse: repeat one frame
    output logic                   irq_o           // Interrupt, level, active high
);

    // ********************************************************
    // Local types and state
    // ********************************************************
    typedef struct packed {
        logic [TX_FIELD_W-1:0] enable;     // Bits 7..5 of the enable register
        logic [DATA_W-1:0]     rd_data;    // Registered read answer
        logic                  irq;        // Registered interrupt level
        logic                  drop;       // Frame delete pulse
        logic                  rpt;        // Frame repeat pulse
        logic                  full_q;     // Previous full level
        logic                  empty_q;    // Previous empty level
        logic [CNT_W-1:0]      ovf_count;  // Deleted frames
        logic [CNT_W-1:0]      unf_count;  // Repeated frames
    } tsbie_state_t;

    tsbie_state_t st;
    tsbie_state_t next_st;

    logic [TX_FIELD_W-1:0] flag_set;
    logic [TX_FIELD_W-1:0] flag_clr;
    logic [TX_FIELD_W-1:0] flags;
    logic                  ovf_evt;
    logic                  unf_evt;
    logic                  full_rise;
    logic                  empty_rise;
    logic                  wr_status;
    logic                  wr_enable;
    logic                  rd_status;

    // ********************************************************
    // Helpers
    // ********************************************************

    // Place the three transmit bits at their positions in a byte
    function automatic logic [DATA_W-1:0] tx_field(input logic [TX_FIELD_W-1:0] f);
        logic [DATA_W-1:0] b;
        b = '0;
        b[TX_FIELD_LSB +: TX_FIELD_W] = f;
        return b;
    endfunction

    // Saturating increment
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c,
                                                 input logic             en);
        logic [CNT_W-1:0] r;
        r = c;
        if (en && (c != {CNT_W{1'b1}})) begin
            r = c + CNT_W'(1);
        end
        return r;
    endfunction

    // ********************************************************
    // Address decode
    // ********************************************************
    assign wr_status = wr_i && (addr_i == OFS_STATUS);
    assign wr_enable = wr_i && (addr_i == OFS_ENABLE);
    assign rd_status = rd_i && (addr_i == OFS_STATUS);

    // ********************************************************
    // Slip event detection
    // ********************************************************

    // Write into a full buffer deletes a frame
    assign ovf_evt    = tx_buf_full_i && tx_buf_wr_i;
    // Read from an empty buffer repeats a frame
    assign unf_evt    = tx_buf_empty_i && tx_buf_rd_i;
    // Buffer has just become full or empty
    assign full_rise  = tx_buf_full_i && !st.full_q;
    assign empty_rise = tx_buf_empty_i && !st.empty_q;

    // Flag set terms
    always_comb begin
        flag_set                = '0;
        flag_set[IDX_OVERFLOW]  = ovf_evt || full_rise;
        flag_set[IDX_UNDERFLOW] = unf_evt || empty_rise;
        flag_set[IDX_SLIP]      = ovf_evt || unf_evt;
    end

    // Flags clear on a status read or on a written one
    always_comb begin
        flag_clr = '0;
        if (rd_status) begin
            flag_clr = '1;
        end else if (wr_status) begin
            flag_clr = wr_data_i[TX_FIELD_LSB +: TX_FIELD_W];
        end
    end

    // ********************************************************
    // Sticky status flags
    // ********************************************************
    tsbie_sticky #(
        .WIDTH (TX_FIELD_W)
    ) u_flags (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .set_i     (flag_set),
        .clr_i     (flag_clr),
        .flag_o    (flags)
    );

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        next_st         = st;
        next_st.full_q  = tx_buf_full_i;
        next_st.empty_q = tx_buf_empty_i;

        // Slip actions to the buffer datapath
        next_st.drop = ovf_evt;
        next_st.rpt  = unf_evt;

        // Slip counters
        next_st.ovf_count = sat_inc(st.ovf_count, ovf_evt);
        next_st.unf_count = sat_inc(st.unf_count, unf_evt);

        // Only bits 7..5 are stored; reserved and low bits are dropped
        if (wr_enable) begin
            next_st.enable = wr_data_i[TX_FIELD_LSB +: TX_FIELD_W];
        end

        // Read answer, valid only in the cycle after the strobe
        next_st.rd_data = RST_RDATA;
        if (rd_i) begin
            unique case (addr_i)
                OFS_STATUS:    next_st.rd_data = tx_field(flags);
                OFS_ENABLE:    next_st.rd_data = tx_field(st.enable);
                OFS_OVF_COUNT: next_st.rd_data = DATA_W'(st.ovf_count);
                OFS_UNF_COUNT: next_st.rd_data = DATA_W'(st.unf_count);
                default:       next_st.rd_data = RST_RDATA;
            endcase
        end

        // Each enable gates its own flag onto the interrupt
        next_st.irq = |(flags & st.enable);
    end

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            st.enable    <= RST_ENABLE;
            st.rd_data   <= RST_RDATA;
            st.irq       <= 1'b0;
            st.drop      <= 1'b0;
            st.rpt       <= 1'b0;
            st.full_q    <= 1'b0;
            st.empty_q   <= 1'b0;
            st.ovf_count <= '0;
            st.unf_count <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign rd_data_o    = st.rd_data;
    assign drop_frame_o = st.drop;
    assign rpt_frame_o  = st.rpt;
    assign irq_o        = st.irq;

endmodule
